// ### design/scp_parser.sv
`timescale 1ns/100ps

// Input character buffer; DEPTH must be a power of two so the pointers wrap freely.
module scp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } scp_fifo_s;

  scp_fifo_s s;
  scp_fifo_s next_s;
  logic push;
  logic pop;

  // Full and empty come straight from the word count.
  assign in_ready = s.count != (AW + 1)'(DEPTH);
  assign out_valid = s.count != '0;
  assign out_data = s.mem[s.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Write, read and count update.
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr_ptr] = in_data;
      next_s.wr_ptr = s.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_s.rd_ptr = s.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_s.count = s.count + 1'b1;
    end else if (pop && !push) begin
      next_s.count = s.count - 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : scp_fifo

module scp_parser (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic unit_valid,
  output scp_pkg::scp_unit_s unit,
  input wire logic unit_ready,
  output logic [3:0] err_count,
  input wire logic err_pop,
  input wire logic settling,
  input wire logic trig_enabled,
  input wire logic trig_external,
  input wire logic trig_in,
  input wire logic transient_armed,
  input wire logic const_voltage,
  input wire logic const_current,
  input wire logic sample_done,
  input wire logic list_running,
  input wire logic transient_done,
  input wire logic list_done,
  input wire logic [15:0] ques_condition,
  input wire logic [7:0] std_event,
  input wire logic resp_avail,
  input wire logic cfg_we,
  input wire logic [1:0] cfg_sel,
  input wire logic [15:0] cfg_data,
  input wire logic rd_req,
  input wire logic [2:0] rd_sel,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic [15:0] operation_condition,
  output logic [7:0] status_byte,
  output logic srq
);
  typedef struct packed {
    scp_pkg::scp_state_e st;
    logic [8*scp_pkg::KW_CHARS-1:0] word;
    logic [3:0] wlen;
    logic kw_seen;
    logic src_skip;
    logic [2:0] depth;
    logic [2:0] base;
    logic [scp_pkg::TREE_LEVELS-1:0][3:0] base_path;
    scp_pkg::scp_unit_s cur;
    scp_pkg::scp_unit_s out;
    logic out_valid;
    logic [3:0] err_cnt;
    logic wtg_hold;
    logic [15:0] oper_cond;
    logic [15:0] ques_cond;
    logic [15:0] oper_evt;
    logic [15:0] ques_evt;
    logic [7:0] std_evt;
    logic [15:0] oper_en;
    logic [15:0] ques_en;
    logic [7:0] std_en;
    logic [7:0] srq_en;
    logic [7:0] sb;
    logic rd_valid;
    logic [15:0] rd_data;
  } scp_core_s;

  scp_core_s s;
  scp_core_s next_s;
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic take;

  // Upper-case a letter; everything else passes unchanged.
  function automatic logic [7:0] upcase(input logic [7:0] c);
    if (c >= scp_pkg::CH_LOWER_A && c <= scp_pkg::CH_LOWER_Z) begin
      return c & ~scp_pkg::CASE_BIT;
    end
    return c;
  endfunction : upcase

  // Letters of a right-aligned, zero-padded word.
  function automatic logic [3:0] kw_len(input logic [8*scp_pkg::KW_CHARS-1:0] w);
    logic [3:0] n;
    n = '0;
    for (int i = 0; i < scp_pkg::KW_CHARS; i++) begin
      if (w[8*i+:8] != 8'h00) begin
        n = 4'(i + 1);
      end
    end
    return n;
  endfunction : kw_len

  // Short form length of a long form.
  function automatic logic [3:0] short_len(input logic [8*scp_pkg::KW_CHARS-1:0] w);
    logic [3:0] l;
    logic [7:0] fourth;
    l = kw_len(w);
    fourth = 8'h00;
    if (l <= 4'h4) begin
      return l;
    end
    fourth = w[8*(l-4'h4)+:8];
    if (fourth == "A" || fourth == "E" || fourth == "I" || fourth == "O" || fourth == "U") begin
      return 4'h3;
    end
    return 4'h4;
  endfunction : short_len

  // Match a received keyword against the table; bit 4 flags a hit.
  function automatic logic [4:0] kw_lookup(input logic [8*scp_pkg::KW_CHARS-1:0] w,
                                           input logic [3:0] n);
    logic [8*scp_pkg::KW_CHARS-1:0] e;
    logic [3:0] l;
    logic [3:0] sl;
    kw_lookup = '0;
    for (int i = 0; i < scp_pkg::KW_ENTRIES; i++) begin
      e = scp_pkg::KW_TABLE[i];
      l = kw_len(e);
      sl = short_len(e);
      // A partial long form matches neither test and is rejected.
      if (w == e || (n == sl && (e >> (8 * (l - sl))) == w)) begin
        kw_lookup = {1'b1, 4'(i)};
      end
    end
  endfunction : kw_lookup

  // Characters are buffered so that a stalled executor pushes back on the source.
  scp_fifo #(
    .WIDTH(8),
    .DEPTH(scp_pkg::FIFO_WORDS)
  ) u_rx_fifo (
    .clk(clk),
    .resetn(resetn),
    .in_valid(rx_valid),
    .in_data(rx_data),
    .in_ready(rx_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(take)
  );

  // A character is consumed while no decoded unit is waiting or while the waiting unit is taken.
  assign take = !s.out_valid || unit_ready;

  // Parser and status model next state.
  always_comb begin
    logic [7:0] c;
    logic [4:0] hit;
    logic fin;
    logic colon;
    logic emit;
    logic lf;
    logic semi;
    logic err;
    logic skip;
    logic [15:0] oper_now;
    logic [15:0] oper_rise;
    logic [15:0] ques_rise;
    logic [7:0] sb_raw;
    next_s = s;
    c = 8'h00;
    hit = '0;
    fin = 1'b0;
    colon = 1'b0;
    emit = 1'b0;
    lf = 1'b0;
    semi = 1'b0;
    err = 1'b0;
    skip = s.src_skip;
    oper_now = '0;
    oper_rise = '0;
    ques_rise = '0;
    sb_raw = '0;
    if (unit_ready) begin
      next_s.out_valid = 1'b0;
    end
    if (fifo_valid && take) begin
      c = (s.st == scp_pkg::ST_QUOTED) ? fifo_data : upcase(fifo_data);
      lf = c == scp_pkg::CH_LF;
      semi = c == scp_pkg::CH_SEMI;
      case (s.st)
        scp_pkg::ST_KEYWORD: begin
          if ((c >= "A" && c <= "Z") || (c >= "0" && c <= "9")
              || (c == scp_pkg::CH_STAR && s.wlen == '0 && !s.kw_seen)) begin
            if (s.wlen == 4'(scp_pkg::KW_CHARS)) begin
              err = 1'b1;
            end else begin
              next_s.word = {s.word[8*scp_pkg::KW_CHARS-9:0], c};
              next_s.wlen = s.wlen + 1'b1;
              if (c == scp_pkg::CH_STAR) begin
                next_s.cur.common = 1'b1;
              end
            end
          end else if (c == scp_pkg::CH_COLON) begin
            if (s.wlen == '0 && !s.kw_seen && !s.cur.common) begin
              next_s.depth = '0;
            end else if (s.wlen == '0 || s.cur.common) begin
              err = 1'b1;
            end else begin
              fin = 1'b1;
              colon = 1'b1;
            end
          end else if (c == scp_pkg::CH_QMARK) begin
            err = s.wlen == '0;
            fin = 1'b1;
            next_s.cur.query = 1'b1;
            next_s.st = scp_pkg::ST_TAIL;
          end else if (c == scp_pkg::CH_SPACE) begin
            // A space right after a semicolon is tolerated between units.
            if (s.wlen != '0) begin
              fin = 1'b1;
              next_s.st = scp_pkg::ST_PARAM_START;
            end else if (s.kw_seen) begin
              err = 1'b1;
            end
          end else if (semi || lf) begin
            if (s.wlen != '0) begin
              fin = 1'b1;
              emit = 1'b1;
            end else if (semi || s.kw_seen) begin
              err = 1'b1;
            end
          end else begin
            err = 1'b1;
          end
        end
        scp_pkg::ST_PARAM_START, scp_pkg::ST_PARAM, scp_pkg::ST_QUOTED: begin
          if (s.st == scp_pkg::ST_QUOTED && lf) begin
            err = 1'b1;
          end else if (s.st != scp_pkg::ST_QUOTED && (semi || lf)) begin
            err = s.st == scp_pkg::ST_PARAM_START;
            emit = 1'b1;
          end else if (s.st == scp_pkg::ST_PARAM_START && (c == scp_pkg::CH_SPACE
                       || c == scp_pkg::CH_COMMA || c == scp_pkg::CH_COLON
                       || c == scp_pkg::CH_QMARK)) begin
            err = 1'b1;
          end else if (s.st == scp_pkg::ST_PARAM && (c == scp_pkg::CH_SPACE
                       || c == scp_pkg::CH_COLON || c == scp_pkg::CH_QMARK)) begin
            next_s.st = scp_pkg::ST_TAIL;
          end else if (s.cur.data_len == 4'(scp_pkg::DATA_CHARS)) begin
            err = 1'b1;
          end else begin
            // Commas stay in the data so that the executor can split a list.
            next_s.cur.data = {s.cur.data[8*scp_pkg::DATA_CHARS-9:0], c};
            next_s.cur.data_len = s.cur.data_len + 1'b1;
            next_s.cur.has_data = 1'b1;
            if (c == scp_pkg::CH_QUOTE) begin
              next_s.st = (s.st == scp_pkg::ST_QUOTED) ? scp_pkg::ST_PARAM
                                                         : scp_pkg::ST_QUOTED;
            end else begin
              next_s.st = (s.st == scp_pkg::ST_QUOTED) ? scp_pkg::ST_QUOTED
                                                         : scp_pkg::ST_PARAM;
            end
          end
        end
        scp_pkg::ST_TAIL: begin
          if (semi || lf) begin
            emit = 1'b1;
          end else if (c == scp_pkg::CH_SPACE && !s.cur.has_data) begin
            next_s.st = scp_pkg::ST_PARAM_START;
          end else begin
            err = 1'b1;
          end
        end
        scp_pkg::ST_DISCARD: begin
          next_s.st = scp_pkg::ST_DISCARD;
        end
        default: begin
          err = 1'b1;
        end
      endcase
      // Close the keyword just collected and place it in the tree.
      if (fin && !err) begin
        next_s.cur.word = s.word;
        next_s.word = '0;
        next_s.wlen = '0;
        next_s.kw_seen = 1'b1;
        if (!s.cur.common) begin
          hit = kw_lookup(s.word, s.wlen);
          if (!hit[4]) begin
            err = 1'b1;
          end else if (hit[3:0] == scp_pkg::KW_SOURCE && s.depth == '0) begin
            skip = 1'b1;
          end else if (s.depth >= 3'(scp_pkg::TREE_LEVELS)) begin
            err = 1'b1;
          end else begin
            next_s.cur.path[s.depth[1:0]] = hit[3:0];
          end
        end
      end
      if (colon && !err) begin
        if (skip) begin
          skip = 1'b0;
        end else begin
          next_s.depth = s.depth + 1'b1;
        end
      end
      next_s.src_skip = skip;
      // Hand over a complete unit; a good one raises no error.
      if (emit && !err) begin
        next_s.out = next_s.cur;
        next_s.out.depth = next_s.depth;
        next_s.out_valid = 1'b1;
        if (!s.cur.common) begin
          next_s.base = next_s.depth;
          next_s.base_path = next_s.cur.path;
        end
      end
      if (err && s.st != scp_pkg::ST_DISCARD) begin
        next_s.st = scp_pkg::ST_DISCARD;
        if (s.err_cnt != scp_pkg::ERRQ_MAX) begin
          next_s.err_cnt = s.err_cnt + 1'b1;
        end
      end
      // Unit end: continue at the saved level, or at the root on a line feed.
      if (semi || lf) begin
        next_s.st = scp_pkg::ST_KEYWORD;
        next_s.cur = '0;
        // A continued unit keeps its parent keywords so the executor sees the full path.
        next_s.cur.path = lf ? '0 : next_s.base_path;
        next_s.word = '0;
        next_s.wlen = '0;
        next_s.kw_seen = 1'b0;
        next_s.src_skip = 1'b0;
        next_s.depth = lf ? 3'h0 : next_s.base;
        if (lf) begin
          next_s.base = '0;
          next_s.base_path = '0;
        end
      end
    end
    // An error pushed in the same cycle as a pop leaves the count unchanged, except at ERRQ_MAX where it drops by one.
    if (err_pop && next_s.err_cnt != '0) begin
      next_s.err_cnt = next_s.err_cnt - 1'b1;
    end
    // Trigger wait flag: an external trigger held low keeps it up until it is high again.
    if (trig_external && !trig_in) begin
      next_s.wtg_hold = 1'b1;
    end else if (trig_in) begin
      next_s.wtg_hold = 1'b0;
    end
    oper_now[scp_pkg::OPER_SETTLING] = settling;
    oper_now[scp_pkg::OPER_WTG] = trig_enabled || s.wtg_hold;
    oper_now[scp_pkg::OPER_ARMED] = transient_armed;
    oper_now[scp_pkg::OPER_CV] = const_voltage;
    oper_now[scp_pkg::OPER_CC] = const_current;
    oper_now[scp_pkg::OPER_SAMPLE] = sample_done;
    oper_now[scp_pkg::OPER_LIST_RUN] = list_running;
    oper_rise = oper_now & ~s.oper_cond;
    oper_rise[scp_pkg::OPER_TRAN_DONE] = transient_done;
    oper_rise[scp_pkg::OPER_LIST_DONE] = list_done;
    ques_rise = ques_condition & ~s.ques_cond;
    next_s.oper_cond = oper_now;
    next_s.ques_cond = ques_condition;
    // Register reads; an event arriving with the clearing read is kept.
    next_s.rd_valid = rd_req;
    if (rd_req) begin
      case (rd_sel)
        scp_pkg::RD_OPER_EVENT: begin
          next_s.rd_data = s.oper_evt;
          next_s.oper_evt = '0;
        end
        scp_pkg::RD_QUES_EVENT: begin
          next_s.rd_data = s.ques_evt;
          next_s.ques_evt = '0;
        end
        scp_pkg::RD_STD_EVENT: begin
          next_s.rd_data = {8'h00, s.std_evt};
          next_s.std_evt = '0;
        end
        scp_pkg::RD_OPER_COND: next_s.rd_data = s.oper_cond;
        scp_pkg::RD_QUES_COND: next_s.rd_data = s.ques_cond;
        scp_pkg::RD_STATUS_BYTE: next_s.rd_data = {8'h00, s.sb};
        default: next_s.rd_data = '0;
      endcase
    end
    next_s.oper_evt = next_s.oper_evt | oper_rise;
    next_s.ques_evt = next_s.ques_evt | ques_rise;
    next_s.std_evt = next_s.std_evt | std_event;
    // Enable writes.
    if (cfg_we) begin
      case (cfg_sel)
        scp_pkg::CFG_OPER_EN: next_s.oper_en = cfg_data;
        scp_pkg::CFG_QUES_EN: next_s.ques_en = cfg_data;
        scp_pkg::CFG_STD_EN: next_s.std_en = cfg_data[7:0];
        default: next_s.srq_en = cfg_data[7:0];
      endcase
    end
    // Status byte summaries; bit 6 is the masked OR of the others.
    sb_raw[scp_pkg::SB_QUES] = |(next_s.ques_evt & next_s.ques_en)
                               || next_s.err_cnt != '0;
    sb_raw[scp_pkg::SB_MAV] = resp_avail;
    sb_raw[scp_pkg::SB_ESB] = |(next_s.std_evt & next_s.std_en);
    sb_raw[scp_pkg::SB_OPER] = |(next_s.oper_evt & next_s.oper_en);
    sb_raw[scp_pkg::SB_RQS] = |(sb_raw & next_s.srq_en);
    next_s.sb = sb_raw;
  end

  // State register.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.st <= scp_pkg::ST_KEYWORD;
      s.oper_en <= scp_pkg::ENABLE_RESET;
      s.ques_en <= scp_pkg::ENABLE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from the state register.
  assign unit_valid = s.out_valid;
  assign unit = s.out;
  assign err_count = s.err_cnt;
  assign rd_valid = s.rd_valid;
  assign rd_data = s.rd_data;
  assign operation_condition = s.oper_cond;
  assign status_byte = s.sb;
  assign srq = s.sb[scp_pkg::SB_RQS];
endmodule : scp_parser

// ### shared/scp_pkg.sv
package scp_pkg;

  // Characters that steer the parser.
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_QUOTE = 8'h22;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_QMARK = 8'h3f;
  localparam logic [7:0] CH_LOWER_A = 8'h61;
  localparam logic [7:0] CH_LOWER_Z = 8'h7a;
  localparam logic [7:0] CASE_BIT = 8'h20;

  // Buffer sizes of the parser.
  localparam int KW_CHARS = 12;
  localparam int DATA_CHARS = 12;
  localparam int TREE_LEVELS = 4;
  localparam int KW_ENTRIES = 16;
  localparam int FIFO_WORDS = 16;
  localparam logic [3:0] ERRQ_MAX = 4'hf;

  // Known long forms, right aligned: the last letter sits in the low byte.
  localparam logic [3:0] KW_SOURCE = 4'h7;
  localparam logic [8*KW_CHARS-1:0] KW_TABLE [KW_ENTRIES] = '{
    96'("ABORT"), 96'("CALIBRATE"), 96'("DISPLAY"), 96'("INITIATE"),
    96'("LIST"), 96'("MEASURE"), 96'("OUTPUT"), 96'("SOURCE"),
    96'("STATUS"), 96'("SYSTEM"), 96'("TRIGGER"), 96'("VOLTAGE"),
    96'("CURRENT"), 96'("OPERATION"), 96'("QUESTIONABLE"), 96'("LEVEL")
  };

  // Operation condition and event bit positions.
  localparam int OPER_SETTLING = 1;
  localparam int OPER_WTG = 5;
  localparam int OPER_ARMED = 6;
  localparam int OPER_CV = 8;
  localparam int OPER_TRAN_DONE = 9;
  localparam int OPER_CC = 10;
  localparam int OPER_SAMPLE = 11;
  localparam int OPER_LIST_DONE = 12;
  localparam int OPER_LIST_RUN = 14;

  // Status byte bit positions.
  localparam int SB_QUES = 3;
  localparam int SB_MAV = 4;
  localparam int SB_ESB = 5;
  localparam int SB_RQS = 6;
  localparam int SB_OPER = 7;

  // Register selects of the status port and reset values of the enables.
  localparam logic [2:0] RD_OPER_EVENT = 3'h0;
  localparam logic [2:0] RD_QUES_EVENT = 3'h1;
  localparam logic [2:0] RD_STD_EVENT = 3'h2;
  localparam logic [2:0] RD_OPER_COND = 3'h3;
  localparam logic [2:0] RD_QUES_COND = 3'h4;
  localparam logic [2:0] RD_STATUS_BYTE = 3'h5;
  localparam logic [1:0] CFG_OPER_EN = 2'h0;
  localparam logic [1:0] CFG_QUES_EN = 2'h1;
  localparam logic [1:0] CFG_STD_EN = 2'h2;
  localparam logic [1:0] CFG_SRQ_EN = 2'h3;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;

  typedef enum logic [5:0] {
    ST_KEYWORD = 6'h01,
    ST_PARAM_START = 6'h02,
    ST_PARAM = 6'h04,
    ST_QUOTED = 6'h08,
    ST_TAIL = 6'h10,
    ST_DISCARD = 6'h20
  } scp_state_e;

  // One decoded message unit as handed to the command executor.
  typedef struct packed {
    logic [TREE_LEVELS-1:0][3:0] path;
    logic [2:0] depth;
    logic query;
    logic common;
    logic [8*KW_CHARS-1:0] word;
    logic has_data;
    logic [8*DATA_CHARS-1:0] data;
    logic [3:0] data_len;
  } scp_unit_s;

endpackage : scp_pkg

// ### test/scp_host.sv
`timescale 1ns/100ps
// Host controller: offers bytes at the falling edge and holds each until it is taken or the bounded wait runs out.
module scp_host (
  input wire logic clk,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  // Waits on a full buffer that ran out; the bench compares this against zero.
  int stalls = 0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  // Every message gets its line feed; the wait on a full buffer is bounded.
  task automatic send(input string msg);
    for (int i = 0; i <= msg.len(); i++) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data = (i == msg.len()) ? scp_pkg::CH_LF : msg[i];
      for (int w = 0; !rx_ready && w < 1000; w++) @(negedge clk);
      if (!rx_ready) begin
        stalls++;
      end
      @(posedge clk);
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data = ~rx_data; // A released line must not look like the last byte.
  endtask : send
endmodule : scp_host

// ### test/scp_parser_properties.sv
`timescale 1ns/100ps
// Port relations of the parser; one clock domain, so clocking and reset are set once.
module scp_parser_properties (
  input wire logic clk,
  input wire logic resetn,
  input wire logic unit_valid,
  input wire logic unit_ready,
  input wire logic [3:0] err_count,
  input wire logic settling,
  input wire logic trig_external,
  input wire logic trig_in,
  input wire logic resp_avail,
  input wire logic rd_req,
  input wire logic rd_valid,
  input wire logic [15:0] operation_condition,
  input wire logic [7:0] status_byte,
  input wire logic srq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Three cycles cover the flag register and the condition register behind it.
  sequence trig_low_s;
    trig_external && !trig_in;
  endsequence
  a_srq_from_rqs: assert property (srq == status_byte[6])
    else $error("srq differs from status bit 6");
  a_unused_oper_zero: assert property ((operation_condition & 16'hb29d) == 16'h0000)
    else $error("unused operation bit set");
  a_error_sets_bit3: assert property (err_count != 4'h0 |-> status_byte[3])
    else $error("error queue not shown in bit 3");
  a_read_gets_answer: assert property (rd_req |=> rd_valid)
    else $error("status read not answered");
  a_unit_held_waiting: assert property (unit_valid && !unit_ready |=> unit_valid)
    else $error("unit dropped before taken");
  a_mav_tracks_resp: assert property (resp_avail [*3] |-> status_byte[4])
    else $error("bit 4 missing with response");
  a_settling_bit_set: assert property (settling [*2] |-> operation_condition[1])
    else $error("settling bit missing");
  a_wait_flag_held: assert property (trig_low_s [*3] |-> operation_condition[5])
    else $error("trigger wait flag not held");
endmodule : scp_parser_properties

// ### test/scp_parser_status_report_tb.sv
`timescale 1ns/100ps
// Feeds messages through the host model, takes units and reads the status registers.
module scp_parser_status_report_tb;
  logic clk, resetn, rx_valid, rx_ready, unit_valid, unit_ready, err_pop, rd_req, rd_valid;
  logic settling, trig_enabled, trig_external, trig_in, transient_armed, const_voltage;
  logic const_current, sample_done, list_running, transient_done, list_done;
  logic resp_avail, cfg_we, srq;
  logic [7:0] rx_data, std_event, status_byte;
  logic [3:0] err_count;
  logic [15:0] ques_condition, cfg_data, rd_data, operation_condition, d;
  logic [1:0] cfg_sel;
  logic [2:0] rd_sel;
  scp_pkg::scp_unit_s unit, u;
  int fail_count, checked;

  scp_host i_host (.*);
  scp_parser i_dut (.*);

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rd(input logic [2:0] sel, output logic [15:0] val);
    @(negedge clk);
    rd_req = 1'b1;
    rd_sel = sel;
    @(negedge clk);
    rd_req = 1'b0;
    val = rd_data;
    check(rd_valid, 1'b1);
  endtask : rd

  task automatic cfg(input logic [1:0] sel, input logic [15:0] val);
    @(negedge clk);
    cfg_we = 1'b1;
    cfg_sel = sel;
    cfg_data = val;
    @(negedge clk);
    cfg_we = 1'b0;
  endtask : cfg

  // Stalls one cycle before taking a unit, so the parser must hold it meanwhile.
  task automatic take(output scp_pkg::scp_unit_s got);
    int w;
    w = 0;
    @(negedge clk);
    while (unit_valid !== 1'b1 && w < 200) begin
      @(negedge clk);
      w++;
    end
    if (unit_valid !== 1'b1) begin
      fail_count++;
      results();
    end
    @(negedge clk);
    got = unit;
    unit_ready = 1'b1;
    @(negedge clk);
    unit_ready = 1'b0;
  endtask : take

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Every input is exercised; the trigger input idles high.
  initial begin
    {resetn, unit_ready, err_pop, rd_req, cfg_we, settling, trig_enabled, trig_external} = '0;
    {transient_armed, const_voltage, const_current, sample_done, list_running} = '0;
    {transient_done, list_done, resp_avail, std_event, ques_condition, cfg_data} = '0;
    {cfg_sel, rd_sel, fail_count, checked} = '0;
    trig_in = 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    check({status_byte, operation_condition, err_count}, 28'h0);
    $display("test reset done");
    fork
      i_host.send("VOLT 5");
      take(u);
    join
    check({u.path[0], u.depth, u.query, u.common, u.has_data}, {4'hb, 3'h0, 3'b001});
    check(u.data[7:0], 8'h35);
    check({err_count, status_byte[3]}, 5'h00);
    $display("test set command done");
    fork
      i_host.send("*CLS;OUTP \"ab\"");
      begin
        take(u);
        check(u.word[31:0], 32'h2a434c53);
        check({u.common, u.query}, 2'b10);
        take(u);
        check({u.path[0], u.depth, u.common, u.data_len}, {4'h6, 3'h0, 1'b0, 4'h4});
        check(u.data[31:0], 32'h22616222);
      end
    join
    $display("test common and quoted done");
    fork
      i_host.send("MEAS:VOLT?;CURR?");
      begin
        take(u);
        check({u.path[0], u.path[1], u.depth, u.query}, {4'h5, 4'hb, 3'h1, 1'b1});
        take(u);
        check({u.path[0], u.path[1], u.depth, u.query}, {4'h5, 4'hc, 3'h1, 1'b1});
      end
    join
    fork
      i_host.send("meas:volt?;:curr?");
      begin
        take(u);
        check({u.path[0], u.depth}, {4'h5, 3'h1});
        take(u);
        check({u.path[0], u.depth, u.query}, {4'hc, 3'h0, 1'b1});
      end
    join
    $display("test tree position done");
    i_host.send("VOLTA 1");
    repeat (3) @(negedge clk);
    check({err_count, status_byte[3], unit_valid}, {4'h1, 2'b10});
    err_pop = 1'b1;
    @(negedge clk);
    err_pop = 1'b0;
    repeat (2) @(negedge clk);
    check({err_count, status_byte[3]}, 5'h00);
    $display("test syntax error done");
    {settling, transient_armed, const_voltage, const_current, sample_done, list_running} = '1;
    {transient_done, list_done} = 2'b11;
    @(negedge clk);
    {transient_done, list_done} = 2'b00;
    repeat (2) @(negedge clk);
    rd(scp_pkg::RD_OPER_COND, d);
    check(d, 16'h4d42);
    rd(scp_pkg::RD_OPER_EVENT, d);
    check(d, 16'h5f42);
    rd(scp_pkg::RD_OPER_EVENT, d);
    check(d, 16'h0000);
    $display("test operation status done");
    ques_condition = 16'h0001;
    repeat (2) @(negedge clk);
    check(status_byte[3], 1'b0);
    cfg(scp_pkg::CFG_QUES_EN, 16'h0001);
    cfg(scp_pkg::CFG_SRQ_EN, 16'h0008);
    resp_avail = 1'b1;
    repeat (4) @(negedge clk);
    check({status_byte[6:3], srq}, 5'b10111);
    rd(scp_pkg::RD_QUES_EVENT, d);
    check(d, 16'h0001);
    @(negedge clk);
    check({status_byte[6:3], srq}, 5'b00100);
    $display("test service request done");
    cfg(scp_pkg::CFG_STD_EN, 16'h0001);
    cfg(scp_pkg::CFG_OPER_EN, 16'h0200);
    {transient_done, std_event} = 9'h101;
    @(negedge clk);
    {transient_done, std_event} = 9'h000;
    rd(scp_pkg::RD_STATUS_BYTE, d);
    check(d, 16'h00b0);
    rd(scp_pkg::RD_STD_EVENT, d);
    check(d, 16'h0001);
    rd(scp_pkg::RD_QUES_COND, d);
    check({d, status_byte}, 24'h000190);
    $display("test event enables done");
    trig_external = 1'b1;
    trig_in = 1'b0;
    repeat (4) @(negedge clk);
    check(operation_condition[5], 1'b1);
    trig_in = 1'b1;
    repeat (4) @(negedge clk);
    check(operation_condition[5], 1'b0);
    trig_enabled = 1'b1;
    repeat (2) @(negedge clk);
    check(operation_condition[5], 1'b1);
    $display("test trigger wait done");
    check(i_host.stalls, 32'h0);
    results();
  end
endmodule : scp_parser_status_report_tb

bind scp_parser scp_parser_properties i_props (.*);
